// ==== rtl/instr_decode_pkg.sv ====
// package for the instruction word decoder: word layout, classes, control struct
// assumes a single 50 MHz clock and synchronous active-low reset
package instr_decode_pkg;
    localparam int WORD_W = 14;
    localparam int FILE_W = 7;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int BIT_W = 3;
    localparam int DEST_POS = 7;
    localparam int BIT_LSB = 7;
    localparam int CLASS_LSB = 12;
    localparam int SUB_LSB = 8;
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [1:0] CLASS_JUMP = 2'h2;
    localparam logic [1:0] CLASS_LIT = 2'h3;
    localparam logic [6:0] FILE_MAX = 7'h7f;
    localparam logic [6:0] ADDR_PC_LOW = 7'h02;
    localparam logic [6:0] ADDR_STATUS = 7'h03;
    localparam int STATUS_C = 0;
    localparam int STATUS_HC = 1;
    localparam int STATUS_Z = 2;
    localparam logic [3:0] SUB_BCF = 4'h0;
    localparam logic [3:0] SUB_BSF = 4'h4;
    localparam logic [3:0] SUB_BTFSC = 4'h8;
    localparam logic [3:0] SUB_BTFSS = 4'hc;
    localparam logic [13:0] WORD_NOP = 14'h0000;
    localparam logic [13:0] WORD_RETURN = 14'h0008;
    localparam logic [13:0] WORD_RETFIE = 14'h0009;
    localparam logic [3:0] SUB_DECFSZ = 4'hb;
    localparam logic [3:0] SUB_INCFSZ = 4'hf;
    localparam logic [3:0] SUB_RETLW = 4'h4;

    typedef enum logic [2:0] {
        ST_FETCH = 3'b001,
        ST_EXEC = 3'b010,
        ST_FLUSH = 3'b100
    } cyc_state_t;

    typedef struct packed {
        logic [1:0] op_class;
        logic [3:0] sub_op;
        logic [6:0] file_addr;
        logic dest_file;
        logic [2:0] bit_num;
        logic [7:0] bit_mask;
        logic [7:0] lit8;
        logic [10:0] lit11;
    } decoded_t;

    typedef struct packed {
        logic write_w;
        logic write_file;
        logic [6:0] addr;
        logic [7:0] data;
        logic load_pc;
        logic [12:0] pc_value;
    } result_t;
endpackage : instr_decode_pkg

// ==== rtl/instruction_word_decoder.sv ====
// instruction word decoder and cycle timer for a small 8-bit core
// assumes program memory presents instr_word stable for the whole cycle and
// that the alu/register file return operands and results combinationally
//
// What this block does
// RQ1: each instruction is one 14-bit word of opcode plus operand fields.
// RQ2: byte operations write the working register when d is 0 and the file when d is 1.
// RQ3: the file operand is a register address from 0x00 to 0x7f.
// RQ4: bit operations pick one of eight bits with b and the register with f.
// RQ5: literal and control operations take an eight- or eleven-bit constant.
// RQ6: don't-care positions decode the same whether 0 or 1; the supplier fills them with 0.
// RQ7: each instruction takes one cycle, two with a no-operation second when a skip or jump happens.
// RQ8: one instruction cycle is exactly four oscillator periods.
// RQ9: a write to the pc low byte loads pc high from the holding latch and the result into pc low.
// RQ10: a status write has its zero, carry and digit-carry bits replaced by the instruction's flags; only byte operations do this, bit set/clear do not.
// RQ11: bit set and clear read the whole register, change one bit and write all eight back.
// RQ12: the prefetched word is thrown away in the no-operation cycle, with no side effects.
`timescale 1ns/10ps
module instruction_word_decoder #(
    parameter int PC_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // program memory side
    input wire logic [13:0] instr_word,
    output logic [12:0] fetch_addr,
    // operand and alu side
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] alu_result,
    input wire logic [2:0] alu_flags,
    input wire logic alu_zero,
    input wire logic [4:0] pc_high_holding_latch,
    input wire logic [12:0] stack_top,
    // decoded controls and results
    output instr_decode_pkg::decoded_t decoded,
    output instr_decode_pkg::result_t result,
    output logic cycle_end,
    output logic [1:0] phase
);
    initial begin
        if (PC_W != 13) $error("pc width must be 13");
    end

    logic [1:0] phase_reg;
    instr_decode_pkg::cyc_state_t state_reg;
    logic [12:0] pc_reg;
    logic flush_reg;
    instr_decode_pkg::decoded_t dec;
    logic bit_val, skip, jump, byte_op, wr_pc, wr_status, bit_rmw;
    logic [7:0] wdata;
    logic [12:0] pc_target;

    // field extraction: class, sub-op and operand positions; don't-care bits land in the fields like any other bit
    always_comb begin
        dec.op_class = instr_word[13:instr_decode_pkg::CLASS_LSB]; // [RQ1]
        dec.sub_op = instr_word[11:instr_decode_pkg::SUB_LSB];
        dec.file_addr = instr_word[instr_decode_pkg::FILE_W-1:0]; // [RQ3]
        dec.dest_file = instr_word[instr_decode_pkg::DEST_POS]; // [RQ2]
        dec.bit_num = instr_word[instr_decode_pkg::BIT_LSB +: instr_decode_pkg::BIT_W]; // [RQ4]
        dec.bit_mask = 8'h01 << dec.bit_num; // [RQ4]
        dec.lit8 = instr_word[instr_decode_pkg::LIT8_W-1:0]; // [RQ5]
        dec.lit11 = instr_word[instr_decode_pkg::LIT11_W-1:0]; // [RQ5]
    end

    // skip and jump detection; literal sub-op bits 9:8 and 8 are don't-care [RQ6]
    always_comb begin
        bit_val = |(file_rdata & dec.bit_mask);
        byte_op = (dec.op_class == instr_decode_pkg::CLASS_BYTE);
        skip = 1'b0;
        jump = 1'b0;
        if (dec.op_class == instr_decode_pkg::CLASS_BIT) begin
            if (dec.sub_op[3:2] == instr_decode_pkg::SUB_BTFSC[3:2]) begin
                skip = !bit_val;
            end else if (dec.sub_op[3:2] == instr_decode_pkg::SUB_BTFSS[3:2]) begin
                skip = bit_val;
            end
        end else if (byte_op) begin
            if (dec.sub_op == instr_decode_pkg::SUB_DECFSZ
                    || dec.sub_op == instr_decode_pkg::SUB_INCFSZ) begin
                skip = alu_zero;
            end
            if (instr_word == instr_decode_pkg::WORD_RETURN
                    || instr_word == instr_decode_pkg::WORD_RETFIE) begin
                jump = 1'b1;
            end
        end else if (dec.op_class == instr_decode_pkg::CLASS_JUMP) begin
            jump = 1'b1;
        end else if (dec.sub_op[3:2] == instr_decode_pkg::SUB_RETLW[3:2]) begin
            jump = 1'b1;
        end
    end

    // write-back value: bit rmw, status flag override
    always_comb begin
        bit_rmw = (dec.op_class == instr_decode_pkg::CLASS_BIT) && !dec.sub_op[3];
        wdata = alu_result;
        if (bit_rmw) begin
            if (dec.sub_op[2]) begin
                wdata = file_rdata | dec.bit_mask; // [RQ11]
            end else begin
                wdata = file_rdata & ~dec.bit_mask; // [RQ11]
            end
        end
        wr_status = (byte_op && dec.dest_file || bit_rmw)
            && dec.file_addr == instr_decode_pkg::ADDR_STATUS;
        if (wr_status && byte_op) begin
            wdata[instr_decode_pkg::STATUS_C] = alu_flags[instr_decode_pkg::STATUS_C]; // [RQ10]
            wdata[instr_decode_pkg::STATUS_HC] = alu_flags[instr_decode_pkg::STATUS_HC]; // [RQ10]
            wdata[instr_decode_pkg::STATUS_Z] = alu_flags[instr_decode_pkg::STATUS_Z]; // [RQ10]
        end
        wr_pc = (byte_op && dec.dest_file || bit_rmw)
            && dec.file_addr == instr_decode_pkg::ADDR_PC_LOW;
    end

    // new pc for a jump, a return or a pc low write; reported with load_pc
    always_comb begin
        pc_target = stack_top;
        if (dec.op_class == instr_decode_pkg::CLASS_JUMP) begin
            pc_target = {pc_high_holding_latch[4:3], dec.lit11};
        end else if (wr_pc) begin
            pc_target = {pc_high_holding_latch, wdata}; // [RQ9]
        end
    end

    // four oscillator periods per instruction cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1; // [RQ8]
        end
    end

    // cycle state: exec normally, flush after a taken skip or pc change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= instr_decode_pkg::ST_FETCH;
            flush_reg <= 1'b0;
            pc_reg <= 13'h0000;
        end else if (phase_reg == instr_decode_pkg::PHASE_LAST) begin
            state_reg <= instr_decode_pkg::ST_EXEC;
            flush_reg <= 1'b0;
            pc_reg <= pc_reg + 13'h0001;
            if (!flush_reg) begin
                if (jump || wr_pc) begin
                    state_reg <= instr_decode_pkg::ST_FLUSH; // [RQ7]
                    flush_reg <= 1'b1;
                    pc_reg <= pc_target; // [RQ9]
                end else if (skip) begin
                    state_reg <= instr_decode_pkg::ST_FLUSH; // [RQ7]
                    flush_reg <= 1'b1;
                end
            end
        end
    end

    // registered outputs; a flushed word produces no writes [RQ12]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result <= '0;
            decoded <= '0;
            cycle_end <= 1'b0;
            phase <= 2'h0;
            fetch_addr <= 13'h0000;
        end else begin
            decoded <= dec;
            phase <= phase_reg;
            fetch_addr <= pc_reg;
            cycle_end <= (phase_reg == instr_decode_pkg::PHASE_LAST);
            result.addr <= dec.file_addr;
            result.data <= wdata;
            result.pc_value <= pc_reg;
            result.write_w <= 1'b0;
            result.write_file <= 1'b0;
            result.load_pc <= 1'b0;
            if (phase_reg == instr_decode_pkg::PHASE_LAST && !flush_reg) begin
                // control words with an all-zero sub-op (no-op, return) leave w alone
                result.write_w <= (byte_op && !dec.dest_file && (|dec.sub_op))
                    || dec.op_class == instr_decode_pkg::CLASS_LIT; // [RQ2]
                result.write_file <= (byte_op && dec.dest_file) || bit_rmw; // [RQ2]
                result.load_pc <= jump || wr_pc; // [RQ9]
                if (jump || wr_pc) begin
                    result.pc_value <= pc_target; // [RQ9]
                end
            end
        end
    end

    property p_flush_no_write; // [RQ12]
        @(posedge clk) disable iff (!rst_n)
        (flush_reg && phase_reg == instr_decode_pkg::PHASE_LAST) |=> !result.write_file
            && !result.write_w;
    endproperty
    a_flush_no_write: assert property (p_flush_no_write) // [RQ12]
        else $error("write during flush");

    property p_phase_step; // [RQ8]
        @(posedge clk) disable iff (!rst_n)
        ##1 1'b1 |-> phase_reg == $past(phase_reg) + 2'h1;
    endproperty
    a_phase_step: assert property (p_phase_step) // [RQ8]
        else $error("phase did not advance");

    sequence s_taken;
        phase_reg == instr_decode_pkg::PHASE_LAST && !flush_reg && (skip || jump);
    endsequence
    property p_two_cycle; // [RQ7]
        @(posedge clk) disable iff (!rst_n)
        s_taken |=> flush_reg [*4] ##1 !flush_reg;
    endproperty
    a_two_cycle: assert property (p_two_cycle) // [RQ7]
        else $error("skip not two cycles");

    property p_dest_w; // [RQ2]
        @(posedge clk) disable iff (!rst_n)
        result.write_w |-> !result.write_file;
    endproperty
    a_dest_w: assert property (p_dest_w) // [RQ2]
        else $error("both destinations written");

    sequence s_quiet_three;
        !cycle_end [*3];
    endsequence
    property p_cycle_period; // [RQ8]
        @(posedge clk) disable iff (!rst_n)
        cycle_end |=> s_quiet_three ##1 cycle_end;
    endproperty
    a_cycle_period: assert property (p_cycle_period) // [RQ8]
        else $error("cycle end not every four clocks");

    property p_flush_state; // [RQ7]
        @(posedge clk) disable iff (!rst_n)
        flush_reg |-> state_reg == instr_decode_pkg::ST_FLUSH;
    endproperty
    a_flush_state: assert property (p_flush_state) // [RQ7]
        else $error("flush cycle without flush state");

    sequence s_pc_write;
        phase_reg == instr_decode_pkg::PHASE_LAST && !flush_reg && wr_pc;
    endsequence
    property p_pc_load; // [RQ9]
        @(posedge clk) disable iff (!rst_n)
        s_pc_write |=> result.load_pc
            && result.pc_value == {$past(pc_high_holding_latch), $past(wdata)};
    endproperty
    a_pc_load: assert property (p_pc_load) // [RQ9]
        else $error("pc low write did not load latch and result");
endmodule : instruction_word_decoder

// ==== tb/prog_mem_model.sv ====
// program memory model: presents one instruction word per cycle
// assumes the bench supplies the next word while cycle_end is high
`timescale 1ns/10ps
module prog_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench and decoder side
    input wire logic cycle_end,
    input wire logic [13:0] word_in,
    output logic [13:0] instr_word
);
    // a new word is taken only at a cycle boundary
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            instr_word <= 14'h0000;
        end else if (cycle_end) begin
            instr_word <= word_in;
        end
    end
endmodule : prog_mem_model

// ==== tb/instruction_word_decoder_tb.sv ====
// self-checking bench for the instruction word decoder
// assumes prog_mem_model feeds the words; operands are driven here
`timescale 1ns/10ps
module instruction_word_decoder_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] word_in = 14'h0000;
    logic [13:0] instr_word;
    logic [7:0] rd = 8'h00;
    logic [7:0] alu = 8'h00;
    logic [2:0] flags = 3'h0;
    logic zero = 1'b0;
    logic [4:0] latch = 5'h00;
    logic [12:0] ret_addr = 13'h0000;
    logic [12:0] exp_pc = 13'h0000;
    logic [12:0] fetch_addr;
    logic cycle_end;
    logic [1:0] phase;
    instr_decode_pkg::decoded_t decoded;
    instr_decode_pkg::result_t result;
    instr_decode_pkg::result_t e;
    logic skip = 1'b0;
    logic chk_data;
    int errors = 0;
    int n_compared = 0;
    int seed = 51;
    logic [13:0] w;
    always #10 clk = ~clk;
    prog_mem_model mem (.clk(clk), .rst_n(rst_n), .cycle_end(cycle_end), .word_in(word_in),
        .instr_word(instr_word));
    instruction_word_decoder dut (.clk(clk), .rst_n(rst_n), .instr_word(instr_word),
        .fetch_addr(fetch_addr), .file_rdata(rd), .alu_result(alu), .alu_flags(flags),
        .alu_zero(zero), .pc_high_holding_latch(latch), .stack_top(ret_addr), .decoded(decoded),
        .result(result), .cycle_end(cycle_end), .phase(phase));
    task automatic give_verdict;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic wait_end(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (cycle_end !== 1'b1 && n < 20);
        if (cycle_end !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: no cycle end", $time);
            give_verdict();
        end
    endtask : wait_end
    // fills e with the expected writes and returns whether a flush follows
    function automatic logic predict(input logic [13:0] x);
        e = '0;
        chk_data = 1'b1;
        predict = 1'b0;
        e.addr = x[6:0];
        e.data = alu;
        if (x[13:12] == instr_decode_pkg::CLASS_BYTE) begin
            e.write_w = !x[7] && x[11:8] != 4'h0;
            e.write_file = x[7];
            chk_data = x[11:8] != 4'h0;
            if (x[7] && x[6:0] == instr_decode_pkg::ADDR_STATUS) e.data[2:0] = flags;
            e.load_pc = x[7] && x[6:0] == instr_decode_pkg::ADDR_PC_LOW;
            e.pc_value = {latch, alu};
            if (x == instr_decode_pkg::WORD_RETURN || x == instr_decode_pkg::WORD_RETFIE) begin
                e.load_pc = 1'b1;
                e.pc_value = ret_addr;
            end
            predict = e.load_pc || (x[11:8] == instr_decode_pkg::SUB_DECFSZ && zero)
                || (x[11:8] == instr_decode_pkg::SUB_INCFSZ && zero);
        end else if (x[13:12] == instr_decode_pkg::CLASS_BIT) begin
            e.write_file = !x[11];
            e.data = x[10] ? (rd | (8'h01 << x[9:7])) : (rd & ~(8'h01 << x[9:7]));
            e.load_pc = !x[11] && x[6:0] == instr_decode_pkg::ADDR_PC_LOW;
            e.pc_value = {latch, e.data};
            predict = e.load_pc || (x[11] && (rd[x[9:7]] == x[10]));
        end else if (x[13:12] == instr_decode_pkg::CLASS_JUMP) begin
            e.load_pc = 1'b1;
            e.pc_value = {latch[4:3], x[10:0]};
            predict = 1'b1;
        end else begin
            e.write_w = 1'b1;
            chk_data = 1'b0;
            e.load_pc = x[11:10] == 2'h1;
            e.pc_value = ret_addr;
            predict = e.load_pc;
        end
    endfunction : predict
    // called at a falling edge while cycle_end is high
    task automatic step(input logic [13:0] x);
        int n;
        logic s;
        word_in = x;
        rd = 8'($random(seed));
        alu = 8'($random(seed));
        flags = 3'($random(seed));
        zero = 1'($random(seed));
        latch = 5'($random(seed));
        ret_addr = 13'($random(seed));
        s = predict(x);
        wait_end(n);
        check(n == 4, "cycle length");
        check(phase === instr_decode_pkg::PHASE_LAST, "phase");
        check(fetch_addr === exp_pc, "fetch address");
        check(decoded.op_class === x[13:12] && decoded.sub_op === x[11:8], "opcode");
        check(decoded.file_addr === x[6:0] && decoded.dest_file === x[7], "file");
        check(decoded.bit_num === x[9:7] && decoded.bit_mask === 8'h01 << x[9:7], "bit");
        check(decoded.lit8 === x[7:0] && decoded.lit11 === x[10:0], "literal");
        if (skip) begin
            check({result.write_w, result.write_file, result.load_pc} === 3'h0, "flush");
            skip = 1'b0;
            exp_pc = exp_pc + 13'h0001;
        end else begin
            check(result.write_w === e.write_w && result.write_file === e.write_file, "dest");
            check(result.load_pc === e.load_pc && (!e.load_pc || result.pc_value === e.pc_value),
                "pc");
            check(!chk_data || !(e.write_w || e.write_file)
                || (result.addr === e.addr && result.data === e.data), "data");
            skip = s;
            exp_pc = e.load_pc ? e.pc_value : exp_pc + 13'h0001;
        end
        @(negedge clk);
    endtask : step
    initial begin
        int n;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        wait_end(n);
        @(negedge clk);
        exp_pc = 13'h0001;
        step(14'h0783);
        step(14'h0782);
        step(14'h0000);
        step(14'h0060);
        step(14'h0008);
        for (int i = 0; i < 200; i++) begin
            w = 14'($random(seed));
            if (w[13:12] == 2'h0 && w[11:8] == 4'h0) w[11:8] = 4'h8;
            if (w[13:12] == 2'h0 && w[6:0] == 7'h03) w[6:0] = 7'h04;
            if (w[13:12] == 2'h3 && w[11:8] == 4'hb) w[11:8] = 4'ha;
            step(w);
        end
        give_verdict();
    end
endmodule : instruction_word_decoder_tb
